/* File: ewrb_bank.sv */
// register bank for endpoint control, fifo status, setup data and waveform engine setup
// assumes a classic wishbone master on clk_i and core status inputs on the same clock
// Overview of operation
// - endpoint 2 fifo total count: 13-bit read-only, high/low registers, zero at reset
// - endpoint 6 count 12 bits, endpoints 4 and 8 11 bits, read-only, zero
// - fifo flag registers read-only: programmable bit2, empty bit1, full bit0, documented resets
// - data endpoint status: full bit3, empty bit2, stall writable, packet count read-only
// - endpoints 2 and 4 status reset 0x28, endpoints 6 and 8 reset 0x04
// - endpoint 0 status resets 0x80: nak control bit7, busy bit1, stall bit0
// - endpoint 1 out and in: busy bit1 read-only, stall bit0 writable, zero
// - endpoint 8 byte count 10 bits writable over high/low; low bit7 is skip
// - setup pointer 16 bits in two bytes; low bit0 reads zero, unwritable
// - setup pointer auto mode in bit0, reset one, other bits zero
// - received setup packet readable as eight read-only bytes in order
// - engine status: done bit7, idle drive select bit0, reset 0x80
// - idle control-line levels in bits 5:0, register resets to 0xff
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
module ewrb_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ewrb_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ep0_busy_i,
  input wire logic ep1_out_busy_i,
  input wire logic ep1_in_busy_i,
  input wire logic [3:0] ep_full_i,
  input wire logic [3:0] ep_empty_i,
  input wire logic [2:0] ep2_packet_count_field_i,
  input wire logic [1:0] ep4_packet_count_field_i,
  input wire logic [2:0] ep6_packet_count_field_i,
  input wire logic [1:0] ep8_packet_count_field_i,
  input wire logic [3:0] fifo_pf_i,
  input wire logic [3:0] fifo_ef_i,
  input wire logic [3:0] fifo_ff_i,
  input wire logic [12:0] ep2_total_i,
  input wire logic [10:0] ep4_total_i,
  input wire logic [11:0] ep6_total_i,
  input wire logic [10:0] ep8_total_i,
  input wire logic setup_load_i,
  input wire logic [63:0] setup_data_i,
  input wire logic engine_done_i,
  output logic handshake_nak_ctrl_o,
  output logic ep0_stall_o,
  output logic ep1_out_stall_o,
  output logic ep1_in_stall_o,
  output logic [3:0] ep_stall_o,
  output logic [9:0] ep8_byte_count_o,
  output logic ep8_skip_o,
  output logic ep8_count_load_o,
  output logic [15:0] setup_ptr_o,
  output logic setup_pointer_auto_mode_o,
  output logic [7:0] waveform_select_o,
  output logic idle_bus_drive_select_o,
  output logic [5:0] idle_ctl_levels_o,
  output logic control_tristate_select_o,
  output logic [5:0] ctl_drive_type_o,
  output logic [8:0] engine_address_o,
  output logic flow_state_enable_o,
  output logic [2:0] flow_state_select_o,
  output logic [7:0] flow_logic_function_o,
  output logic irq_o
);
  import ewrb_pkg::*;

  logic [IDX_W-1:0] idx;
  logic req;
  logic wr;
  logic [7:0] wd;
  logic [7:0] rd_byte;
  logic [7:0] ep_rd [4];
  logic [7:0] setup_mem [SETUP_BYTES];
  logic [2:0] flg_r [4];
  logic [12:0] ep2_tc_r;
  logic [10:0] ep4_tc_r;
  logic [11:0] ep6_tc_r;
  logic [10:0] ep8_tc_r;
  logic [2:0] busy_r;
  logic done_r;
  logic [7:0] idle_lvl_r;
  logic [IRQ_W-1:0] irq_st_r;
  logic [IRQ_W-1:0] irq_msk_r;
  logic [IRQ_W-1:0] irq_ev;
  logic setup_hit;

  assign idx = wb_adr_i[WB_ADR_W-1:2];
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign wd = wb_dat_i[7:0];
  assign setup_hit = (idx[15:3] == IDX_SETUP0[15:3]);

  // bus answer one cycle after the request; writes land on that same edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  // endpoint 0 and 1 control bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      handshake_nak_ctrl_o <= RST_EP0_CS[B_HANDSHAKE_NAK_CTRL];
      ep0_stall_o <= RST_EP0_CS[B_STALL];
      ep1_out_stall_o <= 1'b0;
      ep1_in_stall_o <= 1'b0;
    end else if (wr) begin
      if (idx == IDX_EP0_CS) begin
        handshake_nak_ctrl_o <= wd[B_HANDSHAKE_NAK_CTRL];
        ep0_stall_o <= wd[B_STALL];
      end
      if (idx == IDX_EP1O_CS) begin
        ep1_out_stall_o <= wd[B_STALL];
      end
      if (idx == IDX_EP1I_CS) begin
        ep1_in_stall_o <= wd[B_STALL];
      end
    end
  end

  // endpoint 8 byte count; low write arms the count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ep8_byte_count_o <= 10'h000;
      ep8_count_load_o <= 1'b0;
    end else begin
      ep8_count_load_o <= wr && (idx == IDX_EP8_BCL);
      if (wr && idx == IDX_EP8_BCH) begin
        ep8_byte_count_o[9:8] <= wd[1:0];
      end
      if (wr && idx == IDX_EP8_BCL) begin
        ep8_byte_count_o[7:0] <= wd;
      end
    end
  end
  assign ep8_skip_o = ep8_byte_count_o[7];

  // setup pointer and auto mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setup_ptr_o <= 16'h0000;
      setup_pointer_auto_mode_o <= RST_SDP_AUTO;
    end else if (wr) begin
      if (idx == IDX_SDP_H) begin
        setup_ptr_o[15:8] <= wd;
      end
      if (idx == IDX_SDP_L) begin
        setup_ptr_o[7:0] <= {wd[7:1], 1'b0};
      end
      if (idx == IDX_SDP_CTL) begin
        setup_pointer_auto_mode_o <= wd[0];
      end
    end
  end

  // waveform engine setup
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      waveform_select_o <= RST_WF_SEL;
      idle_bus_drive_select_o <= 1'b0;
      idle_lvl_r <= RST_IDLE_CTL;
      control_tristate_select_o <= 1'b0;
      ctl_drive_type_o <= 6'h00;
      engine_address_o <= 9'h000;
      flow_state_enable_o <= 1'b0;
      flow_state_select_o <= 3'h0;
      flow_logic_function_o <= 8'h00;
    end else if (wr) begin
      case (idx)
        IDX_WF_SEL: waveform_select_o <= wd;
        IDX_DONE_IDLE: idle_bus_drive_select_o <= wd[B_IDLE_BUS_DRIVE_SELECT];
        IDX_IDLE_CTL: idle_lvl_r[5:0] <= wd[5:0];
        IDX_CTL_CFG: begin
          control_tristate_select_o <= wd[B_TRI];
          ctl_drive_type_o <= wd[5:0];
        end
        IDX_ADR_H: engine_address_o[8] <= wd[0];
        IDX_ADR_L: engine_address_o[7:0] <= wd;
        IDX_FLOW_ST: begin
          flow_state_enable_o <= wd[B_FSE];
          flow_state_select_o <= wd[2:0];
        end
        IDX_FLOW_LG: flow_logic_function_o <= wd;
        default: begin
        end
      endcase
    end
  end
  assign idle_ctl_levels_o = idle_lvl_r[5:0];

  // captured core status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_r <= 3'h0;
      done_r <= RST_DONE;
      ep2_tc_r <= 13'h0000;
      ep4_tc_r <= 11'h000;
      ep6_tc_r <= 12'h000;
      ep8_tc_r <= 11'h000;
      flg_r[0] <= RST_FLG_24;
      flg_r[1] <= RST_FLG_24;
      flg_r[2] <= RST_FLG_68;
      flg_r[3] <= RST_FLG_68;
    end else begin
      busy_r <= {ep1_in_busy_i, ep1_out_busy_i, ep0_busy_i};
      done_r <= engine_done_i;
      ep2_tc_r <= ep2_total_i;
      ep4_tc_r <= ep4_total_i;
      ep6_tc_r <= ep6_total_i;
      ep8_tc_r <= ep8_total_i;
      for (int i = 0; i < 4; i++) begin
        flg_r[i] <= {fifo_pf_i[i], fifo_ef_i[i], fifo_ff_i[i]};
      end
    end
  end

  // setup packet buffer, byte 0 from the low end of the packet
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < SETUP_BYTES; i++) begin
        setup_mem[i] <= 8'h00;
      end
    end else if (setup_load_i) begin
      for (int i = 0; i < SETUP_BYTES; i++) begin
        setup_mem[i] <= setup_data_i[8*i +: 8];
      end
    end
  end

  // interrupt status, write one to clear, a new event wins over the clear
  assign irq_ev = {engine_done_i & ~done_r, setup_load_i};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_r <= '0;
      irq_msk_r <= '0;
    end else begin
      if (wr && idx == IDX_IRQ_ST) begin
        irq_st_r <= (irq_st_r & ~wd[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_st_r <= irq_st_r | irq_ev;
      end
      if (wr && idx == IDX_IRQ_MSK) begin
        irq_msk_r <= wd[IRQ_W-1:0];
      end
    end
  end
  assign irq_o = |(irq_st_r & irq_msk_r);

  ewrb_ep_cell #(.CNT_W(3), .RST_VAL(RST_EP24_CS)) u_ep2 (.clk_i(clk_i), .rst_i(rst_i),
    .wr_i(wr && idx == IDX_EP2_CS), .wdat_i(wd[B_STALL]), .full_i(ep_full_i[0]), .empty_i(ep_empty_i[0]),
    .packet_count_field_i(ep2_packet_count_field_i), .stall_o(ep_stall_o[0]), .rd_o(ep_rd[0]));
  ewrb_ep_cell #(.CNT_W(2), .RST_VAL(RST_EP24_CS)) u_ep4 (.clk_i(clk_i), .rst_i(rst_i),
    .wr_i(wr && idx == IDX_EP4_CS), .wdat_i(wd[B_STALL]), .full_i(ep_full_i[1]), .empty_i(ep_empty_i[1]),
    .packet_count_field_i(ep4_packet_count_field_i), .stall_o(ep_stall_o[1]), .rd_o(ep_rd[1]));
  ewrb_ep_cell #(.CNT_W(3), .RST_VAL(RST_EP68_CS)) u_ep6 (.clk_i(clk_i), .rst_i(rst_i),
    .wr_i(wr && idx == IDX_EP6_CS), .wdat_i(wd[B_STALL]), .full_i(ep_full_i[2]), .empty_i(ep_empty_i[2]),
    .packet_count_field_i(ep6_packet_count_field_i), .stall_o(ep_stall_o[2]), .rd_o(ep_rd[2]));
  ewrb_ep_cell #(.CNT_W(2), .RST_VAL(RST_EP68_CS)) u_ep8 (.clk_i(clk_i), .rst_i(rst_i),
    .wr_i(wr && idx == IDX_EP8_CS), .wdat_i(wd[B_STALL]), .full_i(ep_full_i[3]), .empty_i(ep_empty_i[3]),
    .packet_count_field_i(ep8_packet_count_field_i), .stall_o(ep_stall_o[3]), .rd_o(ep_rd[3]));

  // read multiplexer; unmapped indices read zero
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      IDX_EP8_BCH: rd_byte = {6'h00, ep8_byte_count_o[9:8]};
      IDX_EP8_BCL: rd_byte = ep8_byte_count_o[7:0];
      IDX_EP0_CS: rd_byte = {handshake_nak_ctrl_o, 5'h00, busy_r[0], ep0_stall_o};
      IDX_EP1O_CS: rd_byte = {6'h00, busy_r[1], ep1_out_stall_o};
      IDX_EP1I_CS: rd_byte = {6'h00, busy_r[2], ep1_in_stall_o};
      IDX_EP2_CS: rd_byte = ep_rd[0];
      IDX_EP4_CS: rd_byte = ep_rd[1];
      IDX_EP6_CS: rd_byte = ep_rd[2];
      IDX_EP8_CS: rd_byte = ep_rd[3];
      IDX_EP2_FLG: rd_byte = {5'h00, flg_r[0]};
      IDX_EP4_FLG: rd_byte = {5'h00, flg_r[1]};
      IDX_EP6_FLG: rd_byte = {5'h00, flg_r[2]};
      IDX_EP8_FLG: rd_byte = {5'h00, flg_r[3]};
      IDX_EP2_TCH: rd_byte = {3'h0, ep2_tc_r[12:8]};
      IDX_EP2_TCL: rd_byte = ep2_tc_r[7:0];
      IDX_EP4_TCH: rd_byte = {5'h00, ep4_tc_r[10:8]};
      IDX_EP4_TCL: rd_byte = ep4_tc_r[7:0];
      IDX_EP6_TCH: rd_byte = {4'h0, ep6_tc_r[11:8]};
      IDX_EP6_TCL: rd_byte = ep6_tc_r[7:0];
      IDX_EP8_TCH: rd_byte = {5'h00, ep8_tc_r[10:8]};
      IDX_EP8_TCL: rd_byte = ep8_tc_r[7:0];
      IDX_SDP_H: rd_byte = setup_ptr_o[15:8];
      IDX_SDP_L: rd_byte = setup_ptr_o[7:0];
      IDX_SDP_CTL: rd_byte = {7'h00, setup_pointer_auto_mode_o};
      IDX_WF_SEL: rd_byte = waveform_select_o;
      IDX_DONE_IDLE: rd_byte = {done_r, 6'h00, idle_bus_drive_select_o};
      IDX_IDLE_CTL: rd_byte = idle_lvl_r;
      IDX_CTL_CFG: rd_byte = {control_tristate_select_o, 1'b0, ctl_drive_type_o};
      IDX_ADR_H: rd_byte = {7'h00, engine_address_o[8]};
      IDX_ADR_L: rd_byte = engine_address_o[7:0];
      IDX_FLOW_ST: rd_byte = {flow_state_enable_o, 4'h0, flow_state_select_o};
      IDX_FLOW_LG: rd_byte = flow_logic_function_o;
      IDX_IRQ_ST: rd_byte = 8'(irq_st_r);
      IDX_IRQ_MSK: rd_byte = 8'(irq_msk_r);
      default: begin
        if (setup_hit) begin
          rd_byte = setup_mem[idx[2:0]];
        end
      end
    endcase
  end

  // checks
  logic rd_ack;
  logic [IDX_W-1:0] idx_q;
  logic [7:0] su0;
  assign rd_ack = wb_ack_o && !wb_we_i;
  assign su0 = setup_data_i[7:0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_q <= '0;
    end else if (req) begin
      idx_q <= idx;
    end
  end

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a one-cycle answer");
  a_ep2_count_rd: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_ack && idx_q == IDX_EP2_TCH |-> wb_dat_o == {27'h0, $past(ep2_tc_r[12:8])})
    else $error("ep2 total count high read wrong");
  a_count_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> ep4_tc_r == 11'h000 && ep6_tc_r == 12'h000 && ep8_tc_r == 11'h000)
    else $error("fifo totals not zero after reset");
  a_flags_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> flg_r[0] == 3'h2 && flg_r[3] == 3'h6) else $error("fifo flag reset wrong");
  a_stall_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == IDX_EP6_CS |=> ep_stall_o[2] == $past(wd[0])) else $error("ep6 stall not written");
  a_cs_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> ep_rd[1] == 8'h28 && ep_rd[2] == 8'h04) else $error("ep status reset wrong");
  a_ep0_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> handshake_nak_ctrl_o && !ep0_stall_o) else $error("ep0 reset wrong");
  a_ep1_stall: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == IDX_EP1I_CS |=> ep1_in_stall_o == $past(wd[0]) && $stable(ep1_out_stall_o))
    else $error("ep1 in stall not written");
  a_skip_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == IDX_EP8_BCL |=> ep8_skip_o == $past(wd[7]) && ep8_count_load_o)
    else $error("ep8 low write not applied");
  a_ptr_even: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == IDX_SDP_L |=> setup_ptr_o[7:1] == $past(wd[7:1]) && !setup_ptr_o[0])
    else $error("setup pointer low wrong");
  a_auto_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> setup_pointer_auto_mode_o) else $error("auto mode not set at reset");
  a_setup_cap: assert property (@(posedge clk_i) disable iff (rst_i)
    setup_load_i |=> setup_mem[0] == $past(su0)) else $error("setup byte 0 not captured");
  a_done_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> done_r && !idle_bus_drive_select_o) else $error("engine status reset wrong");
  a_idle_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> idle_lvl_r == 8'hff) else $error("idle levels reset wrong");
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_ack && idx_q == IDX_EP0_CS |-> wb_dat_o[6:2] == 5'h00) else $error("reserved bits not zero");
  a_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i)
    setup_load_i && irq_msk_r[IRQ_SETUP] |=> irq_o) else $error("setup interrupt missing");

  c_setup_read: cover property (@(posedge clk_i) disable iff (rst_i) rd_ack && setup_hit);
  c_stall_set: cover property (@(posedge clk_i) disable iff (rst_i) $rose(ep_stall_o[0]));
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
  c_done_edge: cover property (@(posedge clk_i) disable iff (rst_i) irq_ev[IRQ_DONE]);
endmodule // ewrb_bank

/* File: ewrb_pkg.sv */
// constants for the endpoint and waveform register bank
// assumes a 32-bit classic wishbone bus, one 8-bit register per aligned word
package ewrb_pkg;
  localparam int WB_ADR_W = 18;
  localparam int IDX_W = 16;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_EP8_BCH = 16'he69c;
  localparam logic [15:0] IDX_EP8_BCL = 16'he69d;
  localparam logic [15:0] IDX_EP0_CS = 16'he6a0;
  localparam logic [15:0] IDX_EP1O_CS = 16'he6a1;
  localparam logic [15:0] IDX_EP1I_CS = 16'he6a2;
  localparam logic [15:0] IDX_EP2_CS = 16'he6a3;
  localparam logic [15:0] IDX_EP4_CS = 16'he6a4;
  localparam logic [15:0] IDX_EP6_CS = 16'he6a5;
  localparam logic [15:0] IDX_EP8_CS = 16'he6a6;
  localparam logic [15:0] IDX_EP2_FLG = 16'he6a7;
  localparam logic [15:0] IDX_EP4_FLG = 16'he6a8;
  localparam logic [15:0] IDX_EP6_FLG = 16'he6a9;
  localparam logic [15:0] IDX_EP8_FLG = 16'he6aa;
  localparam logic [15:0] IDX_EP2_TCH = 16'he6ab;
  localparam logic [15:0] IDX_EP2_TCL = 16'he6ac;
  localparam logic [15:0] IDX_EP4_TCH = 16'he6ad;
  localparam logic [15:0] IDX_EP4_TCL = 16'he6ae;
  localparam logic [15:0] IDX_EP6_TCH = 16'he6af;
  localparam logic [15:0] IDX_EP6_TCL = 16'he6b0;
  localparam logic [15:0] IDX_EP8_TCH = 16'he6b1;
  localparam logic [15:0] IDX_EP8_TCL = 16'he6b2;
  localparam logic [15:0] IDX_SDP_H = 16'he6b3;
  localparam logic [15:0] IDX_SDP_L = 16'he6b4;
  localparam logic [15:0] IDX_SDP_CTL = 16'he6b5;
  localparam logic [15:0] IDX_SETUP0 = 16'he6b8;
  localparam logic [15:0] IDX_WF_SEL = 16'he6c0;
  localparam logic [15:0] IDX_DONE_IDLE = 16'he6c1;
  localparam logic [15:0] IDX_IDLE_CTL = 16'he6c2;
  localparam logic [15:0] IDX_CTL_CFG = 16'he6c3;
  localparam logic [15:0] IDX_ADR_H = 16'he6c4;
  localparam logic [15:0] IDX_ADR_L = 16'he6c5;
  localparam logic [15:0] IDX_FLOW_ST = 16'he6c6;
  localparam logic [15:0] IDX_FLOW_LG = 16'he6c7;
  localparam logic [15:0] IDX_IRQ_ST = 16'he6f8;
  localparam logic [15:0] IDX_IRQ_MSK = 16'he6f9;
  localparam int SETUP_BYTES = 8;
  // field positions
  localparam int B_STALL = 0;
  localparam int B_BUSY = 1;
  localparam int B_HANDSHAKE_NAK_CTRL = 7;
  localparam int B_DONE = 7;
  localparam int B_IDLE_BUS_DRIVE_SELECT = 0;
  localparam int B_TRI = 7;
  localparam int B_FSE = 7;
  localparam int IRQ_SETUP = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_W = 2;
  // reset values
  localparam logic [7:0] RST_EP0_CS = 8'h80;
  localparam logic [7:0] RST_EP24_CS = 8'h28;
  localparam logic [7:0] RST_EP68_CS = 8'h04;
  localparam logic [2:0] RST_FLG_24 = 3'h2;
  localparam logic [2:0] RST_FLG_68 = 3'h6;
  localparam logic [7:0] RST_WF_SEL = 8'he4;
  localparam logic [7:0] RST_IDLE_CTL = 8'hff;
  localparam logic RST_SDP_AUTO = 1'b1;
  localparam logic RST_DONE = 1'b1;
endpackage

/* File: ewrb_ep_cell.sv */
// one data endpoint status byte: writable stall, captured full, empty, packet count
// assumes status inputs come from logic on the same clock
`timescale 1ns/1ps
module ewrb_ep_cell #(
  parameter int CNT_W = 3,
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic wdat_i,
  input wire logic full_i,
  input wire logic empty_i,
  input wire logic [CNT_W-1:0] packet_count_field_i,
  output logic stall_o,
  output logic [7:0] rd_o
);
  logic full_r;
  logic empty_r;
  logic [CNT_W-1:0] packet_count_field_r;
  logic [2:0] packet_count_field_pad;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stall_o <= RST_VAL[0];
    end else if (wr_i) begin
      stall_o <= wdat_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full_r <= RST_VAL[3];
      empty_r <= RST_VAL[2];
      packet_count_field_r <= RST_VAL[4 +: CNT_W];
    end else begin
      full_r <= full_i;
      empty_r <= empty_i;
      packet_count_field_r <= packet_count_field_i;
    end
  end

  assign packet_count_field_pad = 3'(packet_count_field_r);
  // unused count bits and bits 7 and 1 read zero
  assign rd_o = {1'b0, packet_count_field_pad, full_r, empty_r, 1'b0, stall_o};
endmodule // ewrb_ep_cell

/* File: ewrb_bank_test.sv */
// self-checking bench for the endpoint and waveform register bank
// assumes ewrb_pkg and ewrb_bank are compiled first; the bench drives every port itself
`timescale 1ns/1ps
module ewrb_bank_test;
  import ewrb_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ld, done, ack, nak, s0, irq, skip, b0;
  logic s1o, s1i, auto, idrv, tsel, flow_state_enable;
  logic [7:0] wsel, flog;
  logic [5:0] ictl, dtyp;
  logic [2:0] fsel;
  logic [17:0] adr;
  logic [31:0] dat, rdo, rdat;
  logic [3:0] sel, full, empty, pf, ef, ff, stall;
  logic [2:0] n2, n6;
  logic [1:0] n4, n8;
  logic [12:0] t2;
  logic [10:0] t4, t8;
  logic [11:0] t6;
  logic [63:0] sdat;
  logic [9:0] bc;
  logic [15:0] ptr;
  logic [8:0] eadr;
  int err_total, n_tests;
  // expected bytes for indices 0xe6a0 upwards
  localparam logic [7:0] RST_TAB [40] = '{8'h80, 8'h00, 8'h00, 8'h28, 8'h28, 8'h04, 8'h04, 8'h02, 8'h02, 8'h06,
    8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'he4, 8'h80, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] FF_TAB [40] = '{8'h81, 8'h01, 8'h01, 8'h29, 8'h29, 8'h05, 8'h05, 8'h02, 8'h02, 8'h06,
    8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hfe, 8'h01, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h81, 8'hff, 8'hbf, 8'h01, 8'hff, 8'h87, 8'hff};
  localparam logic [7:0] STS_TAB [19] = '{8'h82, 8'h02, 8'h02, 8'h78, 8'h34, 8'h18, 8'h14, 8'h04, 8'h07, 8'h01,
    8'h02, 8'h1a, 8'hbc, 8'h05, 8'ha5, 8'h0c, 8'h3e, 8'h07, 8'hff};

  ewrb_bank i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdo), .wb_ack_o(ack), .ep0_busy_i(b0), .ep1_out_busy_i(b0),
    .ep1_in_busy_i(b0), .ep_full_i(full), .ep_empty_i(empty), .ep2_packet_count_field_i(n2), .ep4_packet_count_field_i(n4),
    .ep6_packet_count_field_i(n6), .ep8_packet_count_field_i(n8), .fifo_pf_i(pf), .fifo_ef_i(ef), .fifo_ff_i(ff), .ep2_total_i(t2),
    .ep4_total_i(t4), .ep6_total_i(t6), .ep8_total_i(t8), .setup_load_i(ld), .setup_data_i(sdat),
    .engine_done_i(done), .handshake_nak_ctrl_o(nak), .ep0_stall_o(s0), .ep1_out_stall_o(s1o),
    .ep1_in_stall_o(s1i), .ep_stall_o(stall), .ep8_byte_count_o(bc), .ep8_skip_o(skip), .ep8_count_load_o(),
    .setup_ptr_o(ptr), .setup_pointer_auto_mode_o(auto), .waveform_select_o(wsel), .idle_bus_drive_select_o(idrv),
    .idle_ctl_levels_o(ictl), .control_tristate_select_o(tsel), .ctl_drive_type_o(dtyp), .engine_address_o(eadr),
    .flow_state_enable_o(flow_state_enable), .flow_state_select_o(fsel), .flow_logic_function_o(flog), .irq_o(irq));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic cycle; ack and read data taken at the edge that samples ack high
  task automatic xfer(input logic [15:0] idx, input logic w, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1) begin
      err_total++;
      stop_test();
    end
    rdat = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    xfer(idx, 1'b0, 8'h00, 4'hf);
    chk($sformatf("register %h", idx), {24'h0, exp}, rdat);
  endtask

  task automatic idle_inputs;
    // idle levels reproduce the reset values of the captured status
    {b0, ff, n6, n8, t2, t4, t6, t8} <= '0;
    {full, empty, ef, n2, n4, pf} <= {4'h3, 4'hc, 4'hf, 3'h2, 2'h2, 4'hc};
  endtask

  task automatic t_reset;
    for (int i = 0; i < 40; i++) rd(IDX_EP0_CS + 16'(i), RST_TAB[i]);
    rd(IDX_EP8_BCH, 8'h00);
    chk("irq", 1'b0, irq);
  endtask

  task automatic t_status;
    {b0, full, empty, pf, ef, ff} <= {1'b1, 4'h5, 4'ha, 4'h3, 4'ha, 4'h6};
    {n2, n4, n6, n8, t2, t4, t6, t8} <= {3'h7, 2'h3, 3'h1, 2'h1, 13'h1abc, 11'h5a5, 12'hc3e, 11'h7ff};
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 19; i++) rd(IDX_EP0_CS + 16'(i), STS_TAB[i]);
    idle_inputs();
    repeat (2) @(posedge clk_i);
  endtask

  task automatic t_access;
    for (int i = 0; i < 40; i++) xfer(IDX_EP0_CS + 16'(i), 1'b1, 8'hff, 4'h1);
    xfer(IDX_EP8_BCH, 1'b1, 8'hff, 4'h1);
    xfer(IDX_EP8_BCL, 1'b1, 8'hff, 4'h1);
    for (int i = 0; i < 40; i++) rd(IDX_EP0_CS + 16'(i), FF_TAB[i]);
    rd(IDX_EP8_BCH, 8'h03);
    rd(IDX_EP8_BCL, 8'hff);
    chk("stall outputs", {24'h0, 8'hff}, {24'h0, nak, s0, s1o, s1i, stall});
    chk("ep8 count outputs", {21'h0, 10'h3ff, 1'b1}, {21'h0, bc, skip});
    chk("setup pointer", {16'h0, 16'hfffe}, {16'h0, ptr});
    chk("engine outputs", {4'h0, 8'hff, 8'hff, 6'h3f, 6'h3f}, {4'h0, wsel, flog, ictl, dtyp});
    chk("mode outputs", {23'h0, 6'h3f, 3'h7}, {23'h0, auto, idrv, tsel, flow_state_enable, 2'b11, fsel});
    chk("engine address", 9'h1ff, eadr);
    for (int i = 0; i < 40; i++) xfer(IDX_EP0_CS + 16'(i), 1'b1, RST_TAB[i], 4'h1);
    for (int i = 0; i < 40; i++) rd(IDX_EP0_CS + 16'(i), RST_TAB[i]);
  endtask

  task automatic t_setup_irq;
    xfer(IDX_IRQ_ST, 1'b1, 8'h03, 4'h1);
    rd(IDX_IRQ_ST, 8'h00);
    xfer(IDX_IRQ_MSK, 1'b1, 8'h03, 4'h1);
    chk("irq idle", 1'b0, irq);
    @(posedge clk_i);
    ld <= 1'b1;
    sdat <= 64'hf0e1d2c3b4a59687;
    @(posedge clk_i);
    ld <= 1'b0;
    for (int i = 0; i < SETUP_BYTES; i++) rd(IDX_SETUP0 + 16'(i), sdat[8*i +: 8]);
    rd(IDX_IRQ_ST, 8'h01);
    chk("irq raised", 1'b1, irq);
    xfer(IDX_IRQ_MSK, 1'b1, 8'h02, 4'h1);
    @(posedge clk_i);
    chk("irq masked", 1'b0, irq);
    xfer(IDX_IRQ_ST, 1'b1, 8'h01, 4'h1);
    rd(IDX_IRQ_ST, 8'h00);
    done <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(IDX_DONE_IDLE, 8'h00);
    done <= 1'b1;
    rd(IDX_IRQ_ST, 8'h02);
    chk("irq done", 1'b1, irq);
    xfer(IDX_IRQ_ST, 1'b1, 8'h02, 4'h1);
    @(posedge clk_i);
    chk("irq cleared", 1'b0, irq);
  endtask

  task automatic t_bus;
    rd(16'he69a, 8'h00);
    xfer(IDX_WF_SEL, 1'b1, 8'h55, 4'he);
    rd(IDX_WF_SEL, 8'he4);
  endtask

  initial begin
    {cyc, stb, we, ld, adr, dat, sel, sdat} = '0;
    done = 1'b1;
    err_total = 0;
    n_tests = 0;
    idle_inputs();
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_status();
    t_access();
    t_setup_irq();
    t_bus();
    stop_test();
  end
endmodule // ewrb_bank_test
